// [inc/exec_pkg.sv]
// Package for the arithmetic, bit and branch execution slice.
// Assumes a single instruction clock; opcodes come from an external decoder.
package exec_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W   = 15;
	localparam int BOFS_W = 9;
	localparam int NIB_MSB = 3;
	localparam int SIGN_BIT = 7;
	localparam logic [7:0]  W_RESET    = 8'h00;
	localparam logic [14:0] PC_RESET   = 15'h0000;
	localparam logic [6:0]  ADDR_RESET = 7'h00;
	localparam logic [7:0]  DATA_RESET = 8'h00;
	localparam int EXEC_CYCLES_LONG = 2;

	typedef enum logic [3:0] {
		op_none,
		op_add_work_to_file,
		op_add_work_file_carry,
		op_arith_shift_right_file,
		op_bit_clear_file,
		op_bit_set_file,
		op_relative_branch_literal,
		op_relative_branch_working,
		op_test_skip_if_clear
	} op_t;
endpackage

// [rtl/cpu_arith_bit_branch_exec.sv]
// Execution slice of a small 8-bit core: adds, shift, bit ops, branches, skip.
// Assumes the decoder presents one op per cycle with file data already read,
// and waits while busy_o is high (second, no-operation cycle).
// Notes on behaviour
// - Add W and file, route by destination
// - Add W, file, carry; update C DC Z
// - Arithmetic shift right, bit0 to carry
// - Bit clear, flags untouched
// - Bit set, flags untouched
// - Literal branch: PC plus one plus signed offset
// - Literal branch takes two cycles
// - W branch unsigned, two cycles, no flags
// - Skip next when tested bit clear
// - PC change or true test costs two
module cpu_arith_bit_branch_exec
	import exec_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	// Decoded instruction
	input  wire logic              op_valid_i,
	input  op_t                    op_i,
	input  wire logic [ADDR_W-1:0] file_addr_i,
	input  wire logic              dest_sel_i,
	input  wire logic [2:0]        bit_sel_i,
	input  wire logic [BOFS_W-1:0] branch_ofs_i,
	input  wire logic [DATA_W-1:0] file_data_i,
	input  wire logic [PC_W-1:0]   pc_next_i,
	// File write-back
	output logic                   file_we_o,
	output logic [ADDR_W-1:0]      file_waddr_o,
	output logic [DATA_W-1:0]      file_wdata_o,
	// Program counter load
	output logic                   pc_load_o,
	output logic [PC_W-1:0]        program_counter_o,
	// Core state
	output logic [DATA_W-1:0]      work_o,
	output logic                   carry_flag_o,
	output logic                   digit_carry_flag_o,
	output logic                   zero_flag_o,
	output logic                   busy_o,
	output logic                   skip_o
);

	logic              take;
	logic [8:0]        sum;
	logic [4:0]        nib;
	logic [7:0]        res;
	logic              writes_res;
	logic              add_op;
	logic              long_op;
	logic [PC_W-1:0]   next_pc;

	function automatic logic [7:0] bit_mask(input logic [2:0] b);
		bit_mask = 8'h01 << b;
	endfunction

	assign take = op_valid_i && !busy_o;
	assign add_op = op_i inside {op_add_work_to_file, op_add_work_file_carry};

	// Adder with optional carry in
	always_comb begin
		logic cin;
		cin = (op_i == op_add_work_file_carry) ? carry_flag_o : 1'b0;
		sum = {1'b0, work_o} + {1'b0, file_data_i} + {8'h00, cin};
		nib = {1'b0, work_o[NIB_MSB:0]} + {1'b0, file_data_i[NIB_MSB:0]} + {4'h0, cin};
	end

	// Result selection
	always_comb begin
		res = file_data_i;
		writes_res = 1'b1;
		unique case (op_i)
			op_add_work_to_file, op_add_work_file_carry: res = sum[7:0];
			op_arith_shift_right_file: res = {file_data_i[SIGN_BIT], file_data_i[7:1]};
			op_bit_clear_file: res = file_data_i & ~bit_mask(bit_sel_i);
			op_bit_set_file: res = file_data_i | bit_mask(bit_sel_i);
			default: writes_res = 1'b0;
		endcase
	end

	// Branch target and cycle cost
	always_comb begin
		next_pc = pc_next_i;
		long_op = 1'b0;
		unique case (op_i)
			op_relative_branch_literal: begin
				next_pc = pc_next_i + {{(PC_W-BOFS_W){branch_ofs_i[BOFS_W-1]}}, branch_ofs_i};
				long_op = 1'b1;
			end
			op_relative_branch_working: begin
				next_pc = pc_next_i + {{(PC_W-DATA_W){1'b0}}, work_o};
				long_op = 1'b1;
			end
			op_test_skip_if_clear: long_op = !file_data_i[bit_sel_i];
			default: long_op = 1'b0;
		endcase
	end

	// Working register and file write-back routing
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			work_o <= W_RESET;
			file_we_o <= 1'b0;
			file_waddr_o <= ADDR_RESET;
			file_wdata_o <= DATA_RESET;
		end else begin
			file_we_o <= 1'b0;
			if (take && writes_res) begin
				if (dest_sel_i || op_i inside {op_bit_clear_file, op_bit_set_file}) begin
					file_we_o <= 1'b1;
					file_waddr_o <= file_addr_i;
					file_wdata_o <= res;
				end else begin
					work_o <= res;
				end
			end
		end
	end

	// Status flags
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			carry_flag_o <= 1'b0;
			digit_carry_flag_o <= 1'b0;
			zero_flag_o <= 1'b0;
		end else if (take) begin
			if (add_op) begin
				carry_flag_o <= sum[8];
				digit_carry_flag_o <= nib[4];
				zero_flag_o <= (sum[7:0] == 8'h00);
			end else if (op_i == op_arith_shift_right_file) begin
				carry_flag_o <= file_data_i[0];
				zero_flag_o <= (res == 8'h00);
			end
		end
	end

	// Program counter load and two-cycle sequencing
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pc_load_o <= 1'b0;
			program_counter_o <= PC_RESET;
			busy_o <= 1'b0;
			skip_o <= 1'b0;
		end else begin
			pc_load_o <= 1'b0;
			skip_o <= 1'b0;
			busy_o <= 1'b0;
			if (take && long_op) begin
				busy_o <= 1'b1;
				if (op_i == op_test_skip_if_clear) begin
					skip_o <= 1'b1;
				end else begin
					pc_load_o <= 1'b1;
					program_counter_o <= next_pc;
				end
			end
		end
	end

	property p_two_cycle;
		@(posedge clk_sys_i) disable iff (rst_i)
		(pc_load_o || skip_o) |-> busy_o ##1 !busy_o;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("Long op not two cycles");

	property p_bra;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_relative_branch_literal) |=> pc_load_o &&
			program_counter_o == $past(pc_next_i) +
			{{6{$past(branch_ofs_i[8])}}, $past(branch_ofs_i)};
	endproperty
	a_bra: assert property (p_bra) else $error("Literal branch target wrong");

	property p_bra_len;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_relative_branch_literal) |=> busy_o;
	endproperty
	a_bra_len: assert property (p_bra_len) else $error("Literal branch not two cycles");

	property p_brw;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_relative_branch_working) |=> pc_load_o && busy_o &&
			program_counter_o == $past(pc_next_i) + {7'h00, $past(work_o)} &&
			$stable(carry_flag_o) && $stable(zero_flag_o);
	endproperty
	a_brw: assert property (p_brw) else $error("W branch wrong");

	property p_skip;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_test_skip_if_clear) |=>
			skip_o == !$past(file_data_i[bit_sel_i]);
	endproperty
	a_skip: assert property (p_skip) else $error("Skip decision wrong");

	property p_add;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_add_work_to_file && !dest_sel_i) |=>
			work_o == $past(work_o) + $past(file_data_i) && !file_we_o;
	endproperty
	a_add: assert property (p_add) else $error("Add to W wrong");

	property p_addc;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_add_work_file_carry && dest_sel_i) |=> file_we_o &&
			{carry_flag_o, file_wdata_o} ==
			{1'b0, $past(work_o)} + {1'b0, $past(file_data_i)} + {8'h00, $past(carry_flag_o)};
	endproperty
	a_addc: assert property (p_addc) else $error("Add with carry wrong");

	property p_flags_add;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && add_op) |=> zero_flag_o == (work_o == 8'h00 && !file_we_o ||
			file_we_o && file_wdata_o == 8'h00);
	endproperty
	a_flags_add: assert property (p_flags_add) else $error("Zero flag wrong");

	property p_asr;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_arith_shift_right_file && dest_sel_i) |=> file_we_o &&
			file_wdata_o[7] == $past(file_data_i[7]) && carry_flag_o == $past(file_data_i[0]);
	endproperty
	a_asr: assert property (p_asr) else $error("Shift wrong");

	property p_bcf;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_bit_clear_file) |=> file_we_o &&
			!file_wdata_o[$past(bit_sel_i)] && $stable(carry_flag_o) && $stable(zero_flag_o);
	endproperty
	a_bcf: assert property (p_bcf) else $error("Bit clear wrong");

	property p_bsf;
		@(posedge clk_sys_i) disable iff (rst_i)
		(take && op_i == op_bit_set_file) |=> file_we_o &&
			file_wdata_o[$past(bit_sel_i)] && $stable(digit_carry_flag_o);
	endproperty
	a_bsf: assert property (p_bsf) else $error("Bit set wrong");

endmodule

// [testbench/exec_partner.sv]
// Partner model: data memory and program counter beside the execution slice.
// Assumes one clock; writes and counter loads arrive as one-cycle pulses.
module exec_partner (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Data memory
	input  wire logic [6:0]  rd_addr_i,
	output logic      [7:0]  rd_data_o,
	input  wire logic        we_i,
	input  wire logic [6:0]  waddr_i,
	input  wire logic [7:0]  wdata_i,
	// Program counter
	input  wire logic        pc_load_i,
	input  wire logic [14:0] target_i,
	output logic      [14:0] pc_next_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [128];
	logic [14:0] pc;
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i * 37 + 11);
		end
	end
	assign rd_data_o = mem[rd_addr_i];
	assign pc_next_o = pc + 15'h0001;
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pc <= 15'h0000;
		end else if (pc_load_i) begin
			pc <= target_i;
		end else begin
			pc <= pc_next_o;
		end
	end
	always @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end
endmodule

// [testbench/cpu_arith_bit_branch_exec_tb_top.sv]
// Testbench: random ops against a reference model, checked every cycle.
// Assumes the partner model supplies file data and the incremented counter.
module cpu_arith_bit_branch_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import exec_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic op_valid_i, dest_sel_i, file_we_o, pc_load_o, carry_flag_o, digit_carry_flag_o;
	logic zero_flag_o, busy_o, skip_o;
	op_t  op_i;
	logic [6:0]  file_addr_i, file_waddr_o;
	logic [2:0]  bit_sel_i;
	logic [8:0]  branch_ofs_i;
	logic [7:0]  file_data_i, file_wdata_o, work_o;
	logic [14:0] pc_next_i, program_counter_o;
	logic [31:0] r;
	int seed, err_total, check_count, k, fv, pn, s, cin;
	int ew, ec, edc, ez, ewe, ewa, ewd, epl, epc, ebusy, eskip;
	always #12.5 clk_sys_i = ~clk_sys_i;
	cpu_arith_bit_branch_exec i_cpu_arith_bit_branch_exec (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i), .file_addr_i(file_addr_i),
		.dest_sel_i(dest_sel_i), .bit_sel_i(bit_sel_i), .branch_ofs_i(branch_ofs_i),
		.file_data_i(file_data_i), .pc_next_i(pc_next_i), .file_we_o(file_we_o),
		.file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o), .pc_load_o(pc_load_o),
		.program_counter_o(program_counter_o), .work_o(work_o), .carry_flag_o(carry_flag_o),
		.digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o),
		.busy_o(busy_o), .skip_o(skip_o));
	exec_partner i_exec_partner (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.rd_addr_i(file_addr_i), .rd_data_o(file_data_i), .we_i(file_we_o),
		.waddr_i(file_waddr_o), .wdata_i(file_wdata_o), .pc_load_i(pc_load_o),
		.target_i(program_counter_o), .pc_next_o(pc_next_i));
	task automatic chk_val(logic [14:0] got, int exp);
		check_count++;
		if (got !== 15'(exp)) begin
			err_total++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(logic got, int exp);
		check_count++;
		if (got !== 1'(exp)) begin
			err_total++;
			$display("wrong value at %0t: flag %b expected %0d", $time, got, exp);
		end
	endtask
	task automatic put_result(int v);
		if (dest_sel_i) begin
			ewe = 1;
			ewa = int'(file_addr_i);
			ewd = v;
		end else begin
			ew = v;
		end
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		seed = 32'h0000_4e86;
		{op_valid_i, dest_sel_i, file_addr_i, bit_sel_i, branch_ofs_i} = '0;
		op_i = op_none;
		{ew, ec, edc, ez, ewe, ewa, ewd, epl, epc, ebusy, eskip} = '0;
		repeat (10) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'b0;
		for (int n = 0; n < 2000; n++) begin
			@(negedge clk_sys_i);
			chk_val(work_o, ew);
			chk_flag(carry_flag_o, ec);
			chk_flag(digit_carry_flag_o, edc);
			chk_flag(zero_flag_o, ez);
			chk_flag(file_we_o, ewe);
			if (ewe != 0) chk_val(file_waddr_o, ewa);
			if (ewe != 0) chk_val(file_wdata_o, ewd);
			chk_flag(pc_load_o, epl);
			if (epl != 0) chk_val(program_counter_o, epc);
			chk_flag(busy_o, ebusy);
			chk_flag(skip_o, eskip);
			r = $random(seed);
			k = (n < 9) ? n : int'(r[3:0]) % 9;
			op_valid_i = (n < 9) || (r[31:29] != 3'h0);
			op_i = op_t'(k[3:0]);
			{branch_ofs_i, bit_sel_i, dest_sel_i, file_addr_i} = r[23:4];
			#1;
			fv = int'(file_data_i);
			pn = int'(pc_next_i);
			k = (op_valid_i && ebusy == 0) ? k : 0;
			{ewe, epl, eskip, ebusy} = '0;
			case (k)
				1, 2: begin
					cin = (k == 2) ? ec : 0;
					s = ew + fv + cin;
					edc = int'(((ew % 16) + (fv % 16) + cin) > 15);
					ec = int'(s > 255);
					s = s % 256;
					ez = int'(s == 0);
					put_result(s);
				end
				3: begin
					ec = fv % 2;
					s = (fv / 2) + (fv & 128);
					ez = int'(s == 0);
					put_result(s);
				end
				4, 5: begin
					ewe = 1;
					ewa = int'(file_addr_i);
					ewd = (k == 4) ? (fv & ~(1 << bit_sel_i)) : (fv | (1 << bit_sel_i));
				end
				6, 7: begin
					epl = 1;
					ebusy = 1;
					s = (k == 6) ? int'($signed(branch_ofs_i)) : ew;
					epc = (pn + s + 32768) % 32768;
				end
				8: if (((fv >> bit_sel_i) & 1) == 0) begin
					eskip = 1;
					ebusy = 1;
				end
				default: ;
			endcase
		end
		complete_run;
	end
endmodule
